// ===== shared/uhbc_defs.vh
`ifndef UHBC_DEFS_VH
`define UHBC_DEFS_VH
// ----------------------------------------------------------------------------
// Register word indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define UHBC_IDX_CTRL1     8'h05
`define UHBC_IDX_IRQ_EN    8'h06
`define UHBC_IDX_SLV_ADDR  8'h07
`define UHBC_IDX_IRQ_STAT  8'h0D
`define UHBC_IDX_SOF_LO    8'h0E
`define UHBC_IDX_SOF_HI    8'h0F
`define UHBC_IDX_CH_EVT    8'h10
// ----------------------------------------------------------------------------
// Control register 1 fields.
// ----------------------------------------------------------------------------
`define UHBC_C1_SOF_EN     0
`define UHBC_C1_ENG_RST    3
`define UHBC_C1_FORCE      4
`define UHBC_C1_LOW_SPEED  5
`define UHBC_C1_SUSPEND    6
`define UHBC_C1_MASK       8'h79
// ----------------------------------------------------------------------------
// Control register 2 (SOF high) fields.
// ----------------------------------------------------------------------------
`define UHBC_C2_POL_SWAP   6
`define UHBC_C2_CNT_MASK   8'h3F
// ----------------------------------------------------------------------------
// Interrupt bit positions, shared by enable and status; D+ (bit 7) is status only.
// ----------------------------------------------------------------------------
`define UHBC_IRQ_DONE_A    0
`define UHBC_IRQ_DONE_B    1
`define UHBC_IRQ_SOF       4
`define UHBC_IRQ_INSREM    5
`define UHBC_IRQ_DETRES    6
`define UHBC_IRQ_DPLUS     7
`define UHBC_IRQ_MASK      8'h73
// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define UHBC_RST_CTRL1     8'h00
`define UHBC_RST_IRQ_EN    8'h00
`define UHBC_RST_STAT      8'h00
`define UHBC_RST_SOF       14'h0000
// ----------------------------------------------------------------------------
// Timing: SOF counter ticks at 12 MHz; the 10 MHz core approximates it.
// ----------------------------------------------------------------------------
`define UHBC_CLK_HZ        10000000
`define UHBC_SOF_TICK_HZ   12000000
`endif

// ===== core/uhbc_sof_timer.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Frame timer: counts down the programmed interval, 11-bit frame number
// and CRC5 of each frame's token.
// ----------------------------------------------------------------------------
module uhbc_sof_timer #(
   parameter CNT_W = 14
) (
   // Clock and reset.
   input  wire             i_clk,
   input  wire             i_sys_rst,
   // Control.
   input  wire             i_clr,
   input  wire [CNT_W-1:0] i_interval,
   // Status.
   output reg              o_tick,
   output reg  [CNT_W-1:0] o_count,
   output reg  [10:0]      o_frame,
   output reg  [4:0]       o_crc5
);

   function [4:0] crc5_of;
      input [10:0] data;
      integer      k;
      reg   [4:0]  c;
      reg          fb;
      begin
         c = 5'h1F;
         for (k = 0; k < 11; k = k + 1) begin
            fb = c[4] ^ data[k];
            c  = {c[3:0], 1'b0};
            if (fb) begin
               c = c ^ 5'h05;
            end
         end
         crc5_of = ~c;
      end
   endfunction

   reg [10:0] frame_nxt;

   always @* begin
      frame_nxt = o_frame + 11'h001;
   end

   always @(posedge i_clk) begin
      if (i_sys_rst || i_clr) begin
         o_count <= i_interval;
         o_frame <= 11'h000;
         o_tick  <= 1'b0;
         o_crc5  <= crc5_of(11'h000);
      end else if (o_count == {CNT_W{1'b0}}) begin
         o_count <= i_interval;
         o_frame <= frame_nxt;
         o_crc5  <= crc5_of(frame_nxt);
         o_tick  <= 1'b1;
      end else begin
         o_count <= o_count - {{(CNT_W-1){1'b0}}, 1'b1};
         o_tick  <= 1'b0;
      end
   end

endmodule // uhbc_sof_timer

// ===== core/uhbc_bus_ctrl.v
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
`include "uhbc_defs.vh"
// Operation
// RULE1: Speed bit resets to full speed.
// RULE2: Direct low-speed: software sets speed and swap; here the swap bit is ignored and the speed bit alone swaps.
// RULE3: Hub low-speed: full speed, no swap, preamble.
// RULE4: Reset/force pair selects normal, SE0, J, K.
// RULE5: Low speed swaps J and K.
// RULE6: Engine reset and force clear at reset.
// RULE7: Software holds 08h for reset time; here 08h forces J and 10h forces SE0.
// RULE8: Frame generation runs after bus reset ends.
// RULE9: Hardware computes frame number and CRC5.
// RULE10: Software programs interval, enables SOF, arms.
// RULE11: Enables never affect status bits.
// RULE12: Level interrupt while enabled status pending.
// RULE13: Enable bit 6 gates resume or detect.
// RULE14: Enable bit 5 gates attach/detach.
// RULE15: Enable bit 4 gates frame tick.
// RULE16: Channel done events set bits 0 and 1.
// RULE17: Software leaves register 07h alone.
// RULE18: Second channel mirrors the first.
// RULE19: Write one clears status; zero keeps.
// RULE20: Status bit 7 follows D+.
// RULE21: Status bit 5 on SE0/idle transitions.
// RULE22: Status bit 6 absent or resume flag.
// RULE23: Reserved bits read zero, ignore writes.
// RULE24: Interrupt active high, enables clear.
module uhbc_bus_ctrl #(
   parameter CNT_W = 14
) (
   // Clock and reset.
   input  wire        i_clk,
   input  wire        i_sys_rst,
   // Wishbone slave.
   input  wire        i_wb_cyc,
   input  wire        i_wb_stb,
   input  wire        i_wb_we,
   input  wire [7:0]  i_wb_adr,
   input  wire [3:0]  i_wb_sel,
   input  wire [31:0] i_wb_dat,
   output reg  [31:0] o_wb_dat,
   output reg         o_wb_ack,
   // USB line receiver and forced drive.
   input  wire        i_usb_dp,
   input  wire        i_usb_dm,
   output reg         o_usb_dp,
   output reg         o_usb_dm,
   output reg         o_usb_oe,
   // Channel done events from the packet engines.
   input  wire        i_done_a,
   input  wire        i_done_b,
   // Bus state and frame information.
   output reg         o_sof_gen,
   output reg  [10:0] o_frame_num,
   output reg  [4:0]  o_frame_crc5,
   output reg         o_low_speed,
   output reg         o_suspend,
   // Interrupt.
   output reg         o_interrupt_request_out
);

   // -------------------------------------------------------------------------
   // Registers and synchronisers.
   // -------------------------------------------------------------------------
   reg  [7:0]       ctrl1_r;
   reg  [7:0]       irq_en_r;
   reg  [7:0]       stat_r;
   reg  [7:0]       slv_addr_r;
   reg  [7:0]       sof_lo_r;
   reg  [7:0]       sof_hi_r;
   reg  [1:0]       dp_s_r;
   reg  [1:0]       dm_s_r;
   reg  [1:0]       line_r;
   reg  [1:0]       done_r;
   reg  [7:0]       stat_nxt;
   reg  [31:0]      rd_nxt;
   reg  [7:0]       wr_b;
   wire [7:0]       wb_idx;
   wire             wr_stb;
   wire             sof_clr;
   wire             tick;
   wire [CNT_W-1:0] tmr_count;
   wire [10:0]      tmr_frame;
   wire [4:0]       tmr_crc5;
   wire             dp_q;
   wire             dm_q;
   wire             se0;
   wire             idle;
   wire             was_se0;
   wire             was_idle;
   wire             was_j;
   wire             k_now;
   wire             eff_dp;
   wire             eff_dm;
   wire [7:0]       stat_rd;
   wire [7:0]       pend;

   function wr_hit;
      input [7:0] idx;
      begin
         wr_hit = wr_stb && (wb_idx == idx) && i_wb_sel[0];
      end
   endfunction

   assign wb_idx = {2'b00, i_wb_adr[7:2]};
   assign wr_stb = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
   assign sof_clr = wr_hit(`UHBC_IDX_SOF_HI);

   always @* begin
      wr_b = i_wb_dat[7:0];
   end

   // -------------------------------------------------------------------------
   // Wishbone access: answer one cycle after the request, for any address.
   // Unmapped words read zero; writes to them are dropped.
   // -------------------------------------------------------------------------
   always @* begin
      rd_nxt = 32'h00000000;
      case (wb_idx)
         `UHBC_IDX_CTRL1:    rd_nxt[7:0] = ctrl1_r;
         `UHBC_IDX_IRQ_EN:   rd_nxt[7:0] = irq_en_r;                      // [RULE23]
         `UHBC_IDX_SLV_ADDR: rd_nxt[7:0] = slv_addr_r;
         `UHBC_IDX_IRQ_STAT: rd_nxt[7:0] = stat_rd;
         `UHBC_IDX_SOF_LO:   rd_nxt[7:0] = 8'h00;
         `UHBC_IDX_SOF_HI:   rd_nxt[7:0] = tmr_count[CNT_W-1:CNT_W-8];
         default:            rd_nxt = 32'h00000000;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
         o_wb_dat <= rd_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Control registers.
   // -------------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl1_r    <= `UHBC_RST_CTRL1;                                   // [RULE1] [RULE6]
         irq_en_r   <= `UHBC_RST_IRQ_EN;                                  // [RULE24]
         slv_addr_r <= 8'h00;
         sof_lo_r   <= 8'h00;
         sof_hi_r   <= 8'h00;
      end else begin
         if (wr_hit(`UHBC_IDX_CTRL1)) begin
            ctrl1_r <= wr_b & `UHBC_C1_MASK;
         end
         if (wr_hit(`UHBC_IDX_IRQ_EN)) begin
            irq_en_r <= wr_b & `UHBC_IRQ_MASK;                            // [RULE23]
         end
         if (wr_hit(`UHBC_IDX_SLV_ADDR)) begin
            slv_addr_r <= wr_b;
         end
         if (wr_hit(`UHBC_IDX_SOF_LO)) begin
            sof_lo_r <= wr_b;
         end
         if (sof_clr) begin
            sof_hi_r <= wr_b;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Frame timer. A write to the high byte restarts the frame count.
   // -------------------------------------------------------------------------
   uhbc_sof_timer #(
      .CNT_W (CNT_W)
   ) u_sof_timer (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_clr      (sof_clr),
      .i_interval ({sof_hi_r[5:0], sof_lo_r}),
      .o_tick     (tick),
      .o_count    (tmr_count),
      .o_frame    (tmr_frame),
      .o_crc5     (tmr_crc5)
   );                                                                     // [RULE9]

   // -------------------------------------------------------------------------
   // Line sampling: two flip-flops on each pin before any logic.
   // -------------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         dp_s_r <= 2'b00;
         dm_s_r <= 2'b00;
         line_r <= 2'b00;
         done_r <= 2'b00;
      end else begin
         dp_s_r <= {dp_s_r[0], i_usb_dp};
         dm_s_r <= {dm_s_r[0], i_usb_dm};
         line_r <= {dp_q, dm_q};
         done_r <= {i_done_b, i_done_a};
      end
   end

   assign dp_q     = dp_s_r[1];
   assign dm_q     = dm_s_r[1];
   assign se0      = !dp_q && !dm_q;
   // Idle is J or K, one line high, so it ignores the speed bit that makes J look like D- high.
   assign idle     = dp_q ^ dm_q;
   assign was_se0  = (line_r == 2'b00);
   assign was_idle = line_r[1] ^ line_r[0];
   // J and K trade places at low speed, so resume detection follows the speed bit.
   assign was_j    = (line_r == (ctrl1_r[`UHBC_C1_LOW_SPEED] ? 2'b01 : 2'b10));
   assign k_now    = ({dp_q, dm_q} == (ctrl1_r[`UHBC_C1_LOW_SPEED] ? 2'b10 : 2'b01));
   assign eff_dp   = dp_q;
   assign eff_dm   = dm_q;

   // -------------------------------------------------------------------------
   // Interrupt status. Hardware sets win over a same-cycle software clear.
   // -------------------------------------------------------------------------
   always @* begin
      stat_nxt = stat_r;
      if (wr_hit(`UHBC_IDX_IRQ_STAT)) begin
         stat_nxt = stat_nxt & ~(wr_b & `UHBC_IRQ_MASK);                  // [RULE19]
      end
      if (done_r[0]) begin
         stat_nxt[`UHBC_IRQ_DONE_A] = 1'b1;                               // [RULE16]
      end
      if (done_r[1]) begin
         stat_nxt[`UHBC_IRQ_DONE_B] = 1'b1;                               // [RULE18]
      end
      if (tick) begin
         stat_nxt[`UHBC_IRQ_SOF] = 1'b1;
      end
      if ((was_se0 && idle) || (was_idle && se0)) begin
         stat_nxt[`UHBC_IRQ_INSREM] = 1'b1;                               // [RULE21]
      end
      if (ctrl1_r[`UHBC_C1_SUSPEND] && was_j && k_now) begin
         stat_nxt[`UHBC_IRQ_DETRES] = 1'b1;                               // [RULE22]
      end
      stat_nxt = stat_nxt & `UHBC_IRQ_MASK;                               // [RULE23] [RULE11]
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         stat_r <= `UHBC_RST_STAT;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   // Outside suspend, bit 6 is a live absence (SE0) indication, not a latch.
   assign stat_rd = {eff_dp,                                              // [RULE20]
                     ctrl1_r[`UHBC_C1_SUSPEND] ? stat_r[`UHBC_IRQ_DETRES] : se0, // [RULE22]
                     stat_r[5:0]};

   assign pend = stat_rd & irq_en_r & `UHBC_IRQ_MASK;                     // [RULE13] [RULE14] [RULE15]

   // -------------------------------------------------------------------------
   // Outputs: forced line states, frame generation and interrupt level.
   // -------------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_usb_dp                <= 1'b0;
         o_usb_dm                <= 1'b0;
         o_usb_oe                <= 1'b0;
         o_sof_gen               <= 1'b0;
         o_frame_num             <= 11'h000;
         o_frame_crc5            <= 5'h00;
         o_low_speed             <= 1'b0;
         o_suspend               <= 1'b0;
         o_interrupt_request_out <= 1'b0;
      end else begin
         case ({ctrl1_r[`UHBC_C1_ENG_RST], ctrl1_r[`UHBC_C1_FORCE]})      // [RULE4]
            2'b01: begin
               o_usb_dp <= 1'b0;
               o_usb_dm <= 1'b0;
               o_usb_oe <= 1'b1;
            end
            2'b10: begin
               o_usb_dp <= !ctrl1_r[`UHBC_C1_LOW_SPEED];                  // [RULE5]
               o_usb_dm <= ctrl1_r[`UHBC_C1_LOW_SPEED];
               o_usb_oe <= 1'b1;
            end
            2'b11: begin
               o_usb_dp <= ctrl1_r[`UHBC_C1_LOW_SPEED];                   // [RULE5]
               o_usb_dm <= !ctrl1_r[`UHBC_C1_LOW_SPEED];
               o_usb_oe <= 1'b1;
            end
            default: begin
               o_usb_dp <= 1'b0;
               o_usb_dm <= 1'b0;
               o_usb_oe <= 1'b0;
            end
         endcase
         // Tokens leave only with SOF enabled and no forced state active.
         o_sof_gen <= tick && ctrl1_r[`UHBC_C1_SOF_EN]
                      && !ctrl1_r[`UHBC_C1_ENG_RST] && !ctrl1_r[`UHBC_C1_FORCE]; // [RULE8]
         o_frame_num             <= tmr_frame;
         o_frame_crc5            <= tmr_crc5;
         o_low_speed             <= ctrl1_r[`UHBC_C1_LOW_SPEED];
         o_suspend               <= ctrl1_r[`UHBC_C1_SUSPEND];
         o_interrupt_request_out <= |pend;                                // [RULE12] [RULE24]
      end
   end

endmodule // uhbc_bus_ctrl

// ===== bench/uhbc_usb_dev.sv
`timescale 1ns/1ns
// ----------
// Attached device model.
// ----------
module uhbc_usb_dev (
   // Device state.
   input  wire i_attach,
   input  wire i_ls,
   input  wire i_wake,
   // Host forced drive.
   input  wire i_host_dp,
   input  wire i_host_dm,
   input  wire i_host_oe,
   // Resolved line.
   output wire o_dp,
   output wire o_dm
);
   // When absent, the host pull-downs hold both lines low.
   // A full-speed device idles with D+ high; a low-speed device idles with D- high.
   // A wake request turns the idle J into K.
   assign o_dp = i_host_oe ? i_host_dp : (i_attach & (~i_ls ^ i_wake));
   assign o_dm = i_host_oe ? i_host_dm : (i_attach & (i_ls ^ i_wake));
endmodule // uhbc_usb_dev

// ===== bench/uhbc_bus_ctrl_sva.sv
`timescale 1ns/1ns
// ----------
// Port checker.
// ----------
module uhbc_bus_ctrl_sva (
   // Clock and reset.
   input wire        i_clk,
   input wire        i_sys_rst,
   // Register bus.
   input wire        i_wb_cyc,
   input wire        i_wb_stb,
   input wire        i_wb_we,
   input wire [7:0]  i_wb_adr,
   input wire [3:0]  i_wb_sel,
   input wire [31:0] i_wb_dat,
   input wire        o_wb_ack,
   // Lines, events and interrupt.
   input wire        o_usb_dp,
   input wire        o_usb_dm,
   input wire        o_usb_oe,
   input wire        i_done_a,
   input wire        i_done_b,
   input wire        o_sof_gen,
   input wire        o_low_speed,
   input wire        o_suspend,
   input wire        o_interrupt_request_out
);
   // Shadows are taken at the accepting edge, so outputs can be judged later.
   reg  [7:0] ctl_r;
   reg  [7:0] en_r;
   wire       wr_ok  = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_wb_sel[0];
   wire       wr_ctl = wr_ok & (i_wb_adr[7:2] == 6'h05);
   wire       wr_en  = wr_ok & (i_wb_adr[7:2] == 6'h06);
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctl_r <= 8'h00;
         en_r  <= 8'h00;
      end else begin
         if (wr_ctl) ctl_r <= i_wb_dat[7:0];
         if (wr_en) en_r <= i_wb_dat[7:0];
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_reset_quiet: assert property (
      $past(i_sys_rst) |-> !o_usb_oe && !o_low_speed && !o_interrupt_request_out)
      else $error("output active after reset");
   a_force_enable: assert property (
      wr_ctl |-> ##3 o_usb_oe == (ctl_r[3] | ctl_r[4])) else $error("drive enable wrong");
   a_force_se0: assert property (
      wr_ctl ##3 ctl_r[4:3] == 2'b10 |-> !o_usb_dp && !o_usb_dm) else $error("SE0 wrong");
   a_force_jk: assert property (
      wr_ctl ##3 ctl_r[3] |-> o_usb_dp == (ctl_r[4] == ctl_r[5]) && o_usb_dm != o_usb_dp)
      else $error("J or K level wrong");
   a_speed_copy: assert property (
      wr_ctl |-> ##3 o_low_speed == ctl_r[5] && o_suspend == ctl_r[6])
      else $error("speed or suspend copy wrong");
   a_irq_masked: assert property (
      en_r == 8'h00 && $past(en_r) == 8'h00 |-> !o_interrupt_request_out)
      else $error("interrupt with all enables off");
   a_done_a_irq: assert property (
      en_r[0] && $past(en_r[0]) && i_done_a |-> ##[1:4] o_interrupt_request_out)
      else $error("channel A done lost");
   a_done_b_irq: assert property (
      en_r[1] && $past(en_r[1]) && i_done_b |-> ##[1:4] o_interrupt_request_out)
      else $error("channel B done lost");
   a_irq_cause: assert property (
      $rose(o_interrupt_request_out) |-> $past(en_r) != 8'h00) else $error("stray interrupt");
   a_sof_gated: assert property (
      o_sof_gen |-> ctl_r[0] || $past(ctl_r[0])) else $error("frame pulse while disabled");
   c_force: cover property (wr_ctl ##3 o_usb_oe);
   c_irq: cover property ($rose(o_interrupt_request_out));
   c_sof: cover property (o_sof_gen);
endmodule // uhbc_bus_ctrl_sva

bind uhbc_bus_ctrl uhbc_bus_ctrl_sva u_sva (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
   .o_wb_ack(o_wb_ack), .o_usb_dp(o_usb_dp), .o_usb_dm(o_usb_dm), .o_usb_oe(o_usb_oe),
   .i_done_a(i_done_a), .i_done_b(i_done_b), .o_sof_gen(o_sof_gen),
   .o_low_speed(o_low_speed), .o_suspend(o_suspend),
   .o_interrupt_request_out(o_interrupt_request_out));

// ===== bench/uhbc_bus_ctrl_tb_top.sv
`timescale 1ns/1ns
// ----------
// Self-checking bench.
// ----------
module uhbc_bus_ctrl_tb_top;
   localparam [31:0] NO_TICK = 32'hFFFFFFEF;
   localparam [31:0] ALL     = 32'hFFFFFFFF;
   reg         i_clk;
   reg         i_sys_rst;
   reg         i_wb_cyc;
   reg         i_wb_stb;
   reg         i_wb_we;
   reg  [7:0]  i_wb_adr;
   reg  [3:0]  i_wb_sel;
   reg  [31:0] i_wb_dat;
   reg         i_done_a;
   reg         i_done_b;
   reg         attach;
   reg         ls;
   reg         wake;
   reg  [31:0] rd;
   reg  [10:0] fr;
   reg  [2:0]  e;
   wire [31:0] o_wb_dat;
   wire [10:0] o_frame_num;
   wire [4:0]  o_frame_crc5;
   wire        o_wb_ack, o_usb_dp, o_usb_dm, o_usb_oe, o_sof_gen;
   wire        o_low_speed, o_suspend, o_interrupt_request_out, i_usb_dp, i_usb_dm;
   integer     error_cnt, samples_checked, cyc_cnt, i, n;

   uhbc_bus_ctrl uut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_usb_dp(i_usb_dp), .i_usb_dm(i_usb_dm),
      .o_usb_dp(o_usb_dp), .o_usb_dm(o_usb_dm), .o_usb_oe(o_usb_oe), .i_done_a(i_done_a),
      .i_done_b(i_done_b), .o_sof_gen(o_sof_gen), .o_frame_num(o_frame_num),
      .o_frame_crc5(o_frame_crc5), .o_low_speed(o_low_speed), .o_suspend(o_suspend),
      .o_interrupt_request_out(o_interrupt_request_out));
   uhbc_usb_dev u_dev (.i_attach(attach), .i_ls(ls), .i_wake(wake), .i_host_dp(o_usb_dp),
                       .i_host_dm(o_usb_dm), .i_host_oe(o_usb_oe), .o_dp(i_usb_dp),
                       .o_dm(i_usb_dm));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   task waitc(input integer c);
      repeat (c) @(posedge i_clk);
   endtask

   // The request stands until ack is sampled high, so no write is lost.
   task wb(input w, input [5:0] idx, input [7:0] d);
      integer k;
      begin
         @(posedge i_clk);
         i_wb_cyc <= 1'b1;
         i_wb_stb <= 1'b1;
         i_wb_we  <= w;
         i_wb_sel <= 4'hF;
         i_wb_adr <= {idx, 2'b00};
         i_wb_dat <= {24'h000000, d};
         k = 0;
         do begin
            @(posedge i_clk);
            k = k + 1;
         end while (o_wb_ack !== 1'b1 && k < 20);
         rd = o_wb_dat;
         i_wb_cyc <= 1'b0;
         i_wb_stb <= 1'b0;
         if (k >= 20) error_cnt = error_cnt + 1;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // Token CRC5: polynomial 05h, preset ones, data LSB first, result inverted.
   function [4:0] crc5_ref(input [10:0] d);
      integer  b;
      reg [4:0] r;
      begin
         r = 5'h1F;
         for (b = 0; b < 11; b = b + 1)
            r = (r[4] ^ d[b]) ? ({r[3:0], 1'b0} ^ 5'h05) : {r[3:0], 1'b0};
         crc5_ref = ~r;
      end
   endfunction

   task rdchk(input [5:0] idx, input [31:0] exp, input [31:0] msk);
      begin
         wb(1'b0, idx, 8'h00);
         chk(rd & msk, exp);
      end
   endtask

   task ck_irq(input x);
      chk(32'(o_interrupt_request_out), 32'(x));
   endtask

   task t_reset;
      begin
         rdchk(6'h05, 32'h00, ALL);
         rdchk(6'h06, 32'h00, ALL);
         rdchk(6'h0D, 32'h40, NO_TICK);
         rdchk(6'h3F, 32'h00, ALL);
         rdchk(6'h07, 32'h00, ALL);
         wb(1'b1, 6'h06, 8'h40);
         waitc(2);
         ck_irq(1'b1);
         wb(1'b1, 6'h06, 8'hFF);
         rdchk(6'h06, 32'h73, ALL);
         wb(1'b1, 6'h06, 8'h40);
         wb(1'b1, 6'h05, 8'h40);
         wb(1'b1, 6'h0D, 8'hFF);
         waitc(2);
         ck_irq(1'b0);
         rdchk(6'h0D, 32'h00, NO_TICK);
         wb(1'b1, 6'h05, 8'h00);
         wb(1'b1, 6'h06, 8'h00);
      end
   endtask

   task t_force;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            wb(1'b1, 6'h05, {2'b00, i[2], i[1], i[0], 3'b000});
            waitc(3);
            e = {i[1] | i[0], i[0] & (i[1] == i[2]), i[0] & (i[1] != i[2])};
            chk(32'({o_usb_oe, o_usb_dp & o_usb_oe, o_usb_dm & o_usb_oe}), 32'(e));
            chk(32'(o_low_speed), 32'(i[2]));
         end
         wb(1'b1, 6'h05, 8'h00);
         waitc(4);
      end
   endtask

   task t_attach;
      begin
         wb(1'b1, 6'h0D, 8'hFF);
         attach <= 1'b1;
         waitc(6);
         rdchk(6'h0D, 32'hA0, NO_TICK);
         ck_irq(1'b0);
         wb(1'b1, 6'h06, 8'h20);
         waitc(2);
         ck_irq(1'b1);
         wb(1'b1, 6'h0D, 8'h00);
         rdchk(6'h0D, 32'hA0, NO_TICK);
         wb(1'b1, 6'h0D, 8'h20);
         waitc(2);
         ck_irq(1'b0);
         wb(1'b1, 6'h06, 8'h00);
         attach <= 1'b0;
         waitc(6);
         ls <= 1'b1;
         attach <= 1'b1;
         waitc(6);
         rdchk(6'h0D, 32'h20, NO_TICK);
         wb(1'b1, 6'h05, 8'h20);
         wb(1'b1, 6'h0F, 8'h40);
         chk(32'(o_low_speed), 32'h1);
         wb(1'b1, 6'h05, 8'h60);
         wb(1'b1, 6'h0D, 8'hFF);
         wb(1'b1, 6'h06, 8'h40);
         waitc(2);
         ck_irq(1'b0);
         wake <= 1'b1;
         waitc(6);
         ck_irq(1'b1);
         rdchk(6'h0D, 32'hC0, NO_TICK);
         wake <= 1'b0;
         wb(1'b1, 6'h05, 8'h20);
         wb(1'b1, 6'h06, 8'h00);
      end
   endtask

   task t_done;
      begin
         wb(1'b1, 6'h0D, 8'hFF);
         wb(1'b1, 6'h06, 8'h03);
         for (i = 0; i < 2; i = i + 1) begin
            {i_done_b, i_done_a} <= i ? 2'b10 : 2'b01;
            @(posedge i_clk);
            {i_done_b, i_done_a} <= 2'b00;
            waitc(4);
            ck_irq(1'b1);
            wb(1'b1, 6'h0D, i ? 8'h01 : 8'h02);
            waitc(2);
            ck_irq(1'b1);
            rdchk(6'h0D, i ? 32'h02 : 32'h01, NO_TICK);
            wb(1'b1, 6'h0D, 8'h03);
            waitc(2);
            ck_irq(1'b0);
         end
         wb(1'b1, 6'h06, 8'h00);
      end
   endtask

   task t_sof;
      begin
         wb(1'b1, 6'h0E, 8'h14);
         wb(1'b1, 6'h0F, 8'h00);
         wb(1'b1, 6'h05, 8'h09);
         n = 0;
         repeat (60) begin
            @(posedge i_clk);
            if (o_sof_gen === 1'b1) n = n + 1;
         end
         chk(n, 0);
         wb(1'b1, 6'h05, 8'h01);
         wb(1'b1, 6'h0D, 8'hFF);
         wb(1'b1, 6'h06, 8'h10);
         n = 0;
         while (o_sof_gen !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            n = n + 1;
         end
         fr = o_frame_num;
         n = 0;
         do begin
            @(posedge i_clk);
            n = n + 1;
         end while (o_sof_gen !== 1'b1 && n < 50);
         chk(n, 21);
         chk(32'(o_frame_num), 32'(fr + 11'h001));
         chk(32'(o_frame_crc5), 32'(crc5_ref(o_frame_num)));
         ck_irq(1'b1);
      end
   endtask

   task t_rerst;
      begin
         i_sys_rst <= 1'b1;
         waitc(2);
         i_sys_rst <= 1'b0;
         rdchk(6'h05, 32'h00, ALL);
         rdchk(6'h06, 32'h00, ALL);
      end
   endtask

   task close_out;
      begin
         if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask

   always @(posedge i_clk) begin
      cyc_cnt = cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt = error_cnt + 1;
         close_out;
      end
   end

   initial begin
      i_sys_rst = 1'b1;
      i_wb_cyc = 1'b0;
      i_wb_stb = 1'b0;
      i_wb_we = 1'b0;
      i_wb_adr = 8'h00;
      i_wb_sel = 4'hF;
      i_wb_dat = 32'h00000000;
      i_done_a = 1'b0;
      i_done_b = 1'b0;
      attach = 1'b0;
      ls = 1'b0;
      wake = 1'b0;
      error_cnt = 0;
      samples_checked = 0;
      cyc_cnt = 0;
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_reset;
      t_force;
      t_attach;
      t_done;
      t_sof;
      t_rerst;
      close_out;
   end
endmodule // uhbc_bus_ctrl_tb_top
